/* File: logic/pthp_regs.vh */
// Register map, field positions, reset values and timing for pthp
`ifndef PTHP_REGS_VH
`define PTHP_REGS_VH

// Register indexes; byte address is four times the index
`define PTHP_IDX_FORCE      8'hC6
`define PTHP_IDX_INTERVAL   8'hC7
`define PTHP_IDX_BINDING    8'hC8
`define PTHP_IDX_CONFIG     8'hD0
`define PTHP_IDX_STATUS     8'hD1

// Throttle force register fields
`define PTHP_FORCE_DUTY_LSB 0
`define PTHP_FORCE_DUTY_MSB 3
`define PTHP_FORCE_A_BIT    6
`define PTHP_FORCE_B_BIT    7
`define PTHP_FORCE_WMASK    8'hCF

// Interval register fields
`define PTHP_INT_A_LSB      0
`define PTHP_INT_B_LSB      4
`define PTHP_INT_MAX_CODE   4'h9

// Config register fields
`define PTHP_CFG_SHORT_BIT  0

// Reset values
`define PTHP_RST_FORCE      8'h00
`define PTHP_RST_INTERVAL   8'h11
`define PTHP_RST_BINDING    8'h00
`define PTHP_RST_CONFIG     8'h00

// Timing: core clock, throttle tick rate, waveform shape
`define PTHP_CLK_HZ         200000000
`define PTHP_TICK_HZ        22500
`define PTHP_PERIOD_TICKS   7'd80
`define PTHP_DUTY_STEP      7'd5

`endif

/* File: logic/pthp_top.v */
// Processor throttle waveform generator and fan one source binding
//
// Summary of operation
// - Waveform period is 80 ticks at 22.5 kHz
// - Asserted ticks equal (duty code + 1) times five
// - Force bit 6 throttles cpu a hot line
// - Force bit 7 throttles cpu b hot line
// - Shorted lines: either force drives both outputs
// - Interval fields: bits 3:0 cpu a, 7:4 b
// - Codes 0-9 double from 0.73 s; A-F reserved
// - Binding bits 0-3 attach zones a-d
// - Binding bits 4-5 attach cpu hot inputs
// - Binding bits 6-7 attach regulator hot inputs
// - Several bound sources: largest duty wins
// - Zones use lookup; hot inputs use ramps
`timescale 1ns/1ps
`include "pthp_regs.vh"

module pthp_top #(
   parameter TICK_DIV = `PTHP_CLK_HZ / `PTHP_TICK_HZ // Core clocks per tick
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        ce,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        cpu_a_hot_in,
   output wire        cpu_a_hot_out,
   output wire        cpu_a_hot_oe_n,
   input  wire        cpu_b_hot_in,
   output wire        cpu_b_hot_out,
   output wire        cpu_b_hot_oe_n,
   input  wire [1:0]  regulator_hot_inputs,
   input  wire [31:0] zone_lookup_duty,
   input  wire [7:0]  hot_ramp_duty,
   output wire [7:0]  fan_output_one,
   output wire        fan_ramp_request,
   output wire [3:0]  monitor_interval_cpu_a,
   output wire [3:0]  monitor_interval_cpu_b,
   output wire        interval_reserved
);

   // Width of the tick divider counter
   localparam DIV_W = 14;
   // End count of the divider; worked out at 32 bits and then cut to
   // the counter width on purpose, which holds the default count
   localparam [31:0]      DIV_LAST_32 = TICK_DIV - 1;
   localparam [DIV_W-1:0] DIV_LAST    = DIV_LAST_32[DIV_W-1:0];

   // Asserted length of one period for a duty code
   function [6:0] duty_ticks;
      input [3:0] code;
      begin
         duty_ticks = ({3'h0, code} + 7'h01) * `PTHP_DUTY_STEP;
      end
   endfunction

   // Larger of two duty requests
   function [7:0] max8;
      input [7:0] a;
      input [7:0] b;
      begin
         max8 = (a > b) ? a : b;
      end
   endfunction

   // Byte address of a register index
   function [11:0] reg_addr;
      input [7:0] idx;
      begin
         reg_addr = {2'h0, idx, 2'h0};
      end
   endfunction

   // Software-visible registers
   reg  [7:0]       force_ff;       // Throttle force and duty select
   reg  [7:0]       interval_ff;    // Monitoring intervals
   reg  [7:0]       binding_ff;     // Fan one source binding
   reg  [7:0]       config_ff;      // Line shorting configuration
   // Bus answer flops
   reg  [31:0]      prdata_ff;
   reg              pready_ff;
   reg              pslverr_ff;
   // Tick generation and waveform phase
   reg  [DIV_W-1:0] div_ff;         // Core clocks within a tick
   reg  [6:0]       phase_ff;       // Ticks within a period
   // Pin outputs
   reg              a_oe_n_ff;
   reg              b_oe_n_ff;
   reg              hot_out_ff;     // Open drain only ever pulls low
   // Three-stage pin synchronisers, cpu a, cpu b, reg a, reg b
   reg  [3:0]       s1_ff;
   reg  [3:0]       s2_ff;
   reg  [3:0]       s3_ff;
   reg  [3:0]       pin_ff;         // Settled pin levels, high = hot
   // Fan one outputs
   reg  [7:0]       fan_ff;
   reg              ramp_ff;
   reg              rsv_ff;         // Reserved interval code present

   // Combinational next values
   reg  [7:0]       nxt_prdata;
   reg              nxt_slverr;
   reg  [7:0]       nxt_fan;
   reg              nxt_ramp;
   reg  [7:0]       zd;
   integer          i;
   integer          j;              // Loop index of the fan process only

   wire tick      = (div_ff == DIV_LAST);
   wire wave_on   = (phase_ff < duty_ticks(force_ff[3:0]));
   wire force_a   = force_ff[`PTHP_FORCE_A_BIT];
   wire force_b   = force_ff[`PTHP_FORCE_B_BIT];
   wire shorted   = config_ff[`PTHP_CFG_SHORT_BIT];
   wire drive_a   = wave_on & (force_a | (shorted & force_b));
   wire drive_b   = wave_on & (force_b | (shorted & force_a));
   wire setup     = psel & ~penable;
   wire wr_commit = psel & penable & pready_ff & pwrite;
   // Status: settled pins, waveform phase and ramp request
   wire [7:0] status = {2'h0, ramp_ff, wave_on, pin_ff};

   // Bus setup cycle: decode address and prepare the answer
   always @* begin
      nxt_slverr = 1'b0;
      case (paddr)
         reg_addr(`PTHP_IDX_FORCE):    nxt_prdata = force_ff;
         reg_addr(`PTHP_IDX_INTERVAL): nxt_prdata = interval_ff;
         reg_addr(`PTHP_IDX_BINDING):  nxt_prdata = binding_ff;
         reg_addr(`PTHP_IDX_CONFIG):   nxt_prdata = config_ff;
         reg_addr(`PTHP_IDX_STATUS):   nxt_prdata = status;
         default: begin
            // Unmapped: read zero, flag an error
            nxt_prdata = 8'h00;
            nxt_slverr = 1'b1;
         end
      endcase
   end

   // Bus slave: no wait state, answer raised in the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else if (ce) begin
         pready_ff <= setup;
         if (setup) begin
            // Read data is sampled once, so it is stable for the access
            prdata_ff  <= pwrite ? 32'h0000_0000 : {24'h0, nxt_prdata};
            pslverr_ff <= nxt_slverr;
         end else begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
         end
      end
   end

   // Register writes take effect at the completing edge only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         force_ff    <= `PTHP_RST_FORCE;
         interval_ff <= `PTHP_RST_INTERVAL;
         binding_ff  <= `PTHP_RST_BINDING;
         config_ff   <= `PTHP_RST_CONFIG;
      end else if (ce && wr_commit) begin
         case (paddr)
            reg_addr(`PTHP_IDX_FORCE):
               // Reserved bits stay zero
               force_ff <= pwdata[7:0] & `PTHP_FORCE_WMASK;
            reg_addr(`PTHP_IDX_INTERVAL):
               // Changing this while measuring corrupts the count
               interval_ff <= pwdata[7:0];
            reg_addr(`PTHP_IDX_BINDING):
               binding_ff <= pwdata[7:0];
            reg_addr(`PTHP_IDX_CONFIG):
               // Only the shorting bit is implemented
               config_ff <= {7'h00, pwdata[`PTHP_CFG_SHORT_BIT]};
            default: begin
               // Unmapped writes are dropped
            end
         endcase
      end
   end

   // Tick divider and 80-tick period counter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff   <= {DIV_W{1'b0}};
         phase_ff <= 7'h00;
      end else if (ce) begin
         if (tick) begin
            div_ff <= {DIV_W{1'b0}};
            // Wrap after the last tick of the period
            if (phase_ff == `PTHP_PERIOD_TICKS - 7'h01)
               phase_ff <= 7'h00;
            else
               phase_ff <= phase_ff + 7'h01;
         end else begin
            div_ff <= div_ff + {{(DIV_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Hot line drivers; enable low pulls the line
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_oe_n_ff  <= 1'b1;
         b_oe_n_ff  <= 1'b1;
         hot_out_ff <= 1'b0;
      end else if (ce) begin
         a_oe_n_ff  <= ~drive_a;
         b_oe_n_ff  <= ~drive_b;
         hot_out_ff <= 1'b0;
      end
   end

   // Pin synchronisers; a level counts once stages two and three agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff  <= 4'h0;
         s2_ff  <= 4'h0;
         s3_ff  <= 4'h0;
         pin_ff <= 4'h0;
      end else if (ce) begin
         // Lines are active low; store high for hot
         s1_ff <= ~{regulator_hot_inputs[1], regulator_hot_inputs[0],
                    cpu_b_hot_in, cpu_a_hot_in};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         for (i = 0; i < 4; i = i + 1) begin
            if (s2_ff[i] == s3_ff[i])
               pin_ff[i] <= s3_ff[i];
         end
      end
   end

   // Fan one: largest request among bound sources
   always @* begin
      nxt_fan = 8'h00;
      zd      = 8'h00;
      // Zones feed their lookup result directly
      // Own index, so the clocked loop keeps sole ownership of i
      for (j = 0; j < 4; j = j + 1) begin
         zd = zone_lookup_duty[j*8 +: 8];
         if (binding_ff[j])
            nxt_fan = max8(nxt_fan, zd);
      end
      // Hot inputs act only through the ramp logic
      nxt_ramp = (binding_ff[4] & pin_ff[0])
               | (binding_ff[5] & pin_ff[1])
               | (binding_ff[6] & pin_ff[2])
               | (binding_ff[7] & pin_ff[3]);
      if (binding_ff[7:4] != 4'h0)
         nxt_fan = max8(nxt_fan, hot_ramp_duty);
   end

   // Fan one output flops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fan_ff  <= 8'h00;
         ramp_ff <= 1'b0;
      end else if (ce) begin
         fan_ff  <= nxt_fan;
         ramp_ff <= nxt_ramp;
      end
   end

   // Reserved interval code flag, held in a flop so the output is clean
   // Trails an interval write by one clock; software never sees the gap
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsv_ff <= 1'b0;
      end else if (ce) begin
         rsv_ff <= (interval_ff[3:0] > `PTHP_INT_MAX_CODE) |
                   (interval_ff[7:4] > `PTHP_INT_MAX_CODE);
      end
   end

   // Outputs, all straight from flops
   assign prdata                 = prdata_ff;
   assign pready                 = pready_ff;
   assign pslverr                = pslverr_ff;
   assign cpu_a_hot_out          = hot_out_ff;
   assign cpu_b_hot_out          = hot_out_ff;
   assign cpu_a_hot_oe_n         = a_oe_n_ff;
   assign cpu_b_hot_oe_n         = b_oe_n_ff;
   assign fan_output_one         = fan_ff;
   assign fan_ramp_request       = ramp_ff;
   // Interval fields go to the measurement logic outside
   assign monitor_interval_cpu_a = interval_ff[3:0];
   assign monitor_interval_cpu_b = interval_ff[7:4];
   // Reserved codes A-F are flagged, not corrected
   assign interval_reserved      = rsv_ff;

endmodule // pthp_top

/* File: tb/pthp_props.sv */
// Port-level assertions for the throttle block
`timescale 1ns/1ps
module pthp_props #(parameter TICK_DIV = 4) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic [31:0] zone_lookup_duty,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cpu_a_hot_in,
   input wire logic        fan_ramp_request,
   input wire logic        cpu_a_hot_oe_n,
   input wire logic        cpu_b_hot_oe_n,
   input wire logic        interval_reserved,
   input wire logic [7:0]  fan_output_one,
   input wire logic [3:0]  monitor_interval_cpu_a
);
   localparam int SET = 2 * TICK_DIV + 2; // Settle time after a write
   logic [7:0]  frc_ff, ivl_ff, bnd_ff, cfg_ff; // Shadow registers
   logic [15:0] age_ff, low_ff; // Cycles since write; oe low run
   wire wr = psel & penable & pready & pwrite & ~pslverr & ce;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Shadow copies of accepted writes; any accepted write restarts the age
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {frc_ff, ivl_ff, bnd_ff, cfg_ff} <= 32'h0011_0000;
         age_ff <= 16'h0000;
         low_ff <= 16'h0000;
      end else begin
         if (wr && paddr == 12'h318) frc_ff <= pwdata[7:0] & 8'hCF;
         if (wr && paddr == 12'h31C) ivl_ff <= pwdata[7:0];
         if (wr && paddr == 12'h320) bnd_ff <= pwdata[7:0];
         if (wr && paddr == 12'h340) cfg_ff <= pwdata[7:0];
         age_ff <= wr ? 16'h0000 : age_ff + {15'h0, age_ff != 16'hFFFF};
         low_ff <= cpu_a_hot_oe_n ? 16'h0000 : low_ff + 16'h0001;
      end
   end
   // Largest request among bound zones
   function automatic logic [7:0] zmax(logic [7:0] b, logic [31:0] z);
      zmax = 8'h00;
      for (int i = 0; i < 4; i++)
         if (b[i] && z[8*i+:8] > zmax) zmax = z[8*i+:8];
   endfunction
   property p_frc_rd; pready && !pwrite && paddr == 12'h318
      |-> prdata[31:8] == 24'h0 && prdata[5:4] == 2'b00; endproperty
   a_frc_rd: assert property (p_frc_rd) else $error("force rd");
   property p_run; age_ff > low_ff + 2 && frc_ff[3:0] != 4'hF
      |-> low_ff <= (frc_ff[3:0] + 16'h1) * 5 * TICK_DIV; endproperty
   a_run: assert property (p_run) else $error("low run");
   property p_full; age_ff > SET && frc_ff[6] && frc_ff[3:0] == 4'hF
      |-> !cpu_a_hot_oe_n; endproperty
   a_full: assert property (p_full) else $error("full duty");
   property p_idle; age_ff > SET && frc_ff[7:6] == 2'b00
      |-> cpu_a_hot_oe_n && cpu_b_hot_oe_n; endproperty
   a_idle: assert property (p_idle) else $error("idle");
   property p_short; age_ff > SET && cfg_ff[0]
      |-> cpu_a_hot_oe_n == cpu_b_hot_oe_n; endproperty
   a_short: assert property (p_short) else $error("short");
   property p_solo; age_ff > SET && !cfg_ff[0] && frc_ff[7:6] == 2'b01
      |-> cpu_b_hot_oe_n; endproperty
   a_solo: assert property (p_solo) else $error("solo");
   property p_ivl; age_ff > 1 |-> monitor_interval_cpu_a == ivl_ff[3:0] &&
      interval_reserved == (ivl_ff[3:0] > 4'h9 || ivl_ff[7:4] > 4'h9);
   endproperty
   a_ivl: assert property (p_ivl) else $error("interval");
   property p_fan; age_ff > 2 && bnd_ff[7:4] == 4'h0 && $past(ce) |->
      fan_output_one == $past(zmax(bnd_ff, zone_lookup_duty)); endproperty
   a_fan: assert property (p_fan) else $error("fan");
   property p_ramp; (bnd_ff[4] && age_ff > 8) ##0 (!cpu_a_hot_in)[*6]
      |-> fan_ramp_request; endproperty
   a_ramp: assert property (p_ramp) else $error("ramp");
   c_wr: cover property (wr && paddr == 12'h318);
   c_both: cover property (!cpu_a_hot_oe_n && !cpu_b_hot_oe_n);
   c_ramp: cover property (fan_ramp_request);
endmodule // pthp_props
bind pthp_top pthp_props #(.TICK_DIV(TICK_DIV)) i_pthp_props (.pclk,
   .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .zone_lookup_duty, .pready, .pslverr, .cpu_a_hot_in, .fan_ramp_request,
   .cpu_a_hot_oe_n, .cpu_b_hot_oe_n, .interval_reserved, .fan_output_one,
   .monitor_interval_cpu_a);

/* File: tb/pthp_partner.sv */
// Processor and regulator hot pins with board pull-ups
`timescale 1ns/1ps
module pthp_partner (
   input wire logic       a_oe_n,
   input wire logic       b_oe_n,
   input wire logic [3:0] hot_req,  // Parties pulling their line low
   output wire logic      a_line,
   output wire logic      b_line,
   output wire logic [1:0] reg_line
);
   // Open drain: any puller wins, else the pull-up
   assign a_line = a_oe_n & ~hot_req[0];
   assign b_line = b_oe_n & ~hot_req[1];
   assign reg_line = ~hot_req[3:2];
endmodule // pthp_partner

/* File: tb/tb.sv */
// Self-checking bench for the throttle block
`timescale 1ns/1ps
module tb;
   localparam int TD = 4; // Short tick keeps the run brief
   logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, zone = 32'h0, prdata, rd, st = 32'hEA32;
   logic pready, pslverr, a_oe_n, b_oe_n, a_ln, b_ln, ramp, rsv, er, ao, bo;
   logic [1:0] reg_ln;
   logic [3:0] hot = 4'h0, iva, ivb;
   logic [7:0] rdty = 8'h00, fan, b, e;
   int bad_count = 0, num_checks = 0, mdl[int], n, k, ca, cb, x;
   int dl[4] = '{0, 9, 15, 3}; // Duty codes per throttle case
   initial forever #2.5 pclk = ~pclk;
   pthp_top #(.TICK_DIV(TD)) i_pthp_top (.pclk, .presetn, .ce, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .cpu_a_hot_in(a_ln), .cpu_a_hot_out(ao), .cpu_a_hot_oe_n(a_oe_n),
      .cpu_b_hot_in(b_ln), .cpu_b_hot_out(bo), .cpu_b_hot_oe_n(b_oe_n),
      .regulator_hot_inputs(reg_ln), .zone_lookup_duty(zone),
      .hot_ramp_duty(rdty), .fan_output_one(fan), .fan_ramp_request(ramp),
      .monitor_interval_cpu_a(iva), .monitor_interval_cpu_b(ivb),
      .interval_reserved(rsv));
   pthp_partner i_pthp_partner (.a_oe_n, .b_oe_n, .hot_req(hot),
      .a_line(a_ln), .b_line(b_ln), .reg_line(reg_ln));
   // Xorshift source for stimulus
   function automatic logic [31:0] rnd();
      st ^= st << 13;
      st ^= st >> 17;
      st ^= st << 5;
      return st;
   endfunction
   // Model: largest zone request among those bound in bv
   function automatic logic [7:0] zmx(logic [7:0] bv, logic [31:0] z);
      zmx = 8'h00;
      for (int j = 0; j < 4; j++)
         if (bv[j] && z[8*j+:8] > zmx) zmx = z[8*j+:8];
   endfunction
   task automatic chk(string nm, logic [31:0] ex, logic [31:0] g);
      num_checks++;
      if (g !== ex) begin
         bad_count++;
         $display("wrong value %s exp %h got %h", nm, ex, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      k = 0;
      do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
      if (k >= 50) begin
         bad_count++;
         final_report();
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   // Write and mirror into the model; throttle bits 5:4 stay zero
   task automatic wr(logic [11:0] a, logic [31:0] d);
      bus(1, a, d);
      if (mdl.exists(a)) mdl[a] = d[7:0] & (a == 12'h318 ? 8'hCF : 8'hFF);
   endtask
   task automatic rdchk(logic [11:0] a);
      bus(0, a, 32'h0);
      chk("rdata", mdl.exists(a) ? mdl[a] : 0, rd);
      chk("slverr", !mdl.exists(a), er);
   endtask
   initial begin
      mdl[12'h318] = 0;
      mdl[12'h31C] = 8'h11;
      mdl[12'h320] = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      foreach (mdl[a]) rdchk(a);
      rdchk(12'h3FC);
      wr(12'h318, 32'hFFFFFFFF);
      rdchk(12'h318);
      wr(12'h318, 32'h0);
      // Interval codes only change while throttling is idle
      for (n = 0; n < 8; n++) begin
         wr(12'h31C, rnd());
         rdchk(12'h31C);
         x = mdl[12'h31C];
         chk("ivl", x, {ivb, iva});
         chk("rsv", (x & 15) > 9 || (x >> 4) > 9, rsv);
      end
      // Waveform low time over one full period, both lines
      foreach (dl[i]) begin
         wr(12'h340, i == 3);
         wr(12'h318, (i[0] ? 8'h80 : 8'h40) | dl[i]);
         repeat (200 * TD) @(posedge pclk);
         ca = 0;
         cb = 0;
         repeat (80 * TD) begin
            @(posedge pclk);
            ca += !a_oe_n;
            cb += !b_oe_n;
         end
         x = (dl[i] + 1) * 5 * TD;
         chk("low_a", (!i[0] || i == 3) ? x : 0, ca);
         chk("low_b", i[0] ? x : 0, cb);
         chk("hot_out", 2'b00, {ao, bo});
      end
      wr(12'h318, 32'h0);
      wr(12'h340, 32'h0);
      // Zone binding: largest bound request reaches the fan
      for (n = 0; n < 10; n++) begin
         b = rnd() & 15;
         wr(12'h320, b);
         rdchk(12'h320);
         zone <= rnd();
         rdty <= rnd();
         repeat (3) @(posedge pclk);
         chk("fan", zmx(b, zone), fan);
      end
      // Each hot source raises the ramp only when bound and active
      for (n = 0; n < 4; n++) begin
         wr(12'h320, 8'h10 << n);
         hot <= 4'(1 << ((n + 1) % 4));
         repeat (8) @(posedge pclk);
         chk("ramp_off", 0, ramp);
         hot <= 4'(1 << n);
         repeat (8) @(posedge pclk);
         chk("ramp_on", 1, ramp);
         chk("fan_hot", rdty, fan);
         // Status shows the settled pin and the ramp; wave bit varies
         bus(0, 12'h344, 32'h0);
         chk("status", 32'h20 | (1 << n), rd & 32'hEF);
         hot <= 4'h0;
      end
      // Clock enable low freezes the fan output
      wr(12'h320, 32'hF);
      zone <= rnd();
      repeat (3) @(posedge pclk);
      e = zmx(8'hF, zone);
      chk("fan", e, fan);
      ce <= 0;
      zone <= rnd();
      repeat (5) @(posedge pclk);
      chk("fan_hold", e, fan);
      ce <= 1;
      repeat (3) @(posedge pclk);
      chk("fan", zmx(8'hF, zone), fan);
      final_report();
   end
endmodule // tb
